// ---- serial_adc_convert_strobe_port_tb.sv ----
// bench for the converter port
// host model drives the link
`timescale 1ns/100ps
`default_nettype none
module serial_adc_convert_strobe_port_tb;
	logic CORE_CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [13:0] AIN_DIFF_I = 14'h0000;
	wire SCK_I, CONVERT_STROBE_I, SDO_O, SDO_OE_O, ACQUIRE_O, NAP_O, SLEEP_O;
	logic [15:0] w, n;
	int bad_count = 0;
	int n_checks = 0;
	initial forever #50 CORE_CLK_I = ~CORE_CLK_I;
	ssc_convert_strobe_port ssc_convert_strobe_port_inst(.CORE_CLK_I, .RST_N_I, .SCK_I, .CONVERT_STROBE_I,
		.AIN_DIFF_I, .SDO_O, .SDO_OE_O, .ACQUIRE_O, .NAP_O, .SLEEP_O);
	ssc_host_model ssc_host_model_inst(.sdo_i(SDO_O), .oe_i(SDO_OE_O), .sck_o(SCK_I),
		.cnv_o(CONVERT_STROBE_I));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		@(negedge CORE_CLK_I);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// word out is the one taken at the previous start
	task automatic run_frame(input logic [15:0] exp, input logic [13:0] next);
		@(posedge CORE_CLK_I) AIN_DIFF_I <= next;
		ssc_host_model_inst.frame(w, n);
		check(w, exp);
		check(n, 16'h0010);
	endtask
	task automatic test_power;
		repeat (2) ssc_host_model_inst.pulse();
		check({14'h0000, NAP_O, SLEEP_O}, 16'h0002);
		repeat (2) ssc_host_model_inst.pulse();
		check({14'h0000, NAP_O, SLEEP_O}, 16'h0001);
		ssc_host_model_inst.tick();
		repeat (6) @(posedge CORE_CLK_I);
		check({14'h0000, NAP_O, SLEEP_O}, 16'h0000);
		repeat (2) ssc_host_model_inst.pulse();
		repeat (8) ssc_host_model_inst.tick();
		run_frame(16'h1fff, 14'h1fff);
		$display("power done");
	endtask
	initial begin
		repeat (20) @(posedge CORE_CLK_I);
		RST_N_I <= 1'b1;
		run_frame(16'h0000, 14'h2a5c);
		run_frame(16'h2a5c, 14'h1fff);
		run_frame(16'h1fff, 14'h1fff);
		$display("frames done");
		test_power();
		report_and_stop();
	end
	// tests need about 15 us
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- ssc_cfg.svh ----
// constants for the serial converter control port
// assumes inclusion by bare name from the package and the design file
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// result word and frame geometry
`define SSC_WORD_W 14
`define SSC_FRAME_W 16
`define SSC_CNT_W 4
`define SSC_LAST_EDGE 4'hf
`define SSC_CNT_ZERO 4'h0
`define SSC_CNT_ONE 4'h1

// power-down pulse counting while the serial clock is static
`define SSC_PULSE_W 3
`define SSC_PULSE_ZERO 3'h0
`define SSC_PULSE_ONE 3'h1
`define SSC_NAP_PULSES 3'h2
`define SSC_SLEEP_PULSES 3'h4

`endif

// ---- ssc_convert_strobe_port.sv ----
// serial sampling-converter control port: convert strobe, serial clock, three-state data out
// assumes the serial clock is free of glitches and the converted word arrives as a quasi-static bus
//
// Contract
// (RULE1) A convert strobe rising edge freezes the input word and starts a conversion.
// (RULE2) Conversion steps and output bits advance only on serial clock rising edges.
// (RULE3) The serial output is three-state and released when no bits are presented.
// (RULE4) Each word shifted out is the input captured at the previous conversion start.
// (RULE5) Any serial clock pulse wakes the port from sleep, and the host must give one.
// (RULE6) Two convert pulses with the serial clock static put the port into nap.
// (RULE7) Four or more convert pulses with the serial clock static put the port into sleep.
// (RULE8) Convert edges are ignored until 16 serial clock rising edges follow a start.
// (RULE9) The full result word is delivered within 16 serial clock periods of a start.
// (RULE10) Acquisition runs from the 16th serial clock rising edge to the next convert edge.
// (RULE11) After a wake from nap a convert strobe is accepted again within a clock cycle; the code holds it off until pd_s2 clears, two serial clock rises later.
// (RULE12) The output is driven only while shifting, and released in nap and sleep; the code keeps a frame stopped mid-shift driven until SCK_I resumes.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_cfg.svh"

module ssc_convert_strobe_port
	import ssc_pkg::*;
(
	// core clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// serial link from the host
	input wire logic SCK_I,
	input wire logic CONVERT_STROBE_I,
	// converted input word from the sample-and-hold
	input wire logic [`SSC_WORD_W-1:0] AIN_DIFF_I,
	// three-state serial data
	output logic SDO_O,
	output logic SDO_OE_O,
	// status
	output logic ACQUIRE_O,
	output logic NAP_O,
	output logic SLEEP_O
);

	ssc_core_t core;
	ssc_core_t next_core;
	ssc_link_t link;
	ssc_link_t next_link;

	logic sck_rise;
	logic cnv_rise_core;
	logic cnv_rise_link;
	logic powered_down;

	// core domain: watches the pins for power-down patterns
	// a lone serial clock pulse is shorter than a core period and could slip
	// between samples, so activity arrives as a link-domain toggle instead
	assign sck_rise = core.tog_s2 ^ core.tog_s3;
	assign cnv_rise_core = core.cnv_s2 & ~core.cnv_s3;

	always_comb begin
		next_core = core;
		next_core.tog_s1 = link.sck_tog;
		next_core.tog_s2 = core.tog_s1;
		next_core.tog_s3 = core.tog_s2;
		next_core.cnv_s1 = CONVERT_STROBE_I;
		next_core.cnv_s2 = core.cnv_s1;
		next_core.cnv_s3 = core.cnv_s2;
		if (sck_rise) begin
			// wake wins over a convert pulse in the same cycle
			next_core.pulses = `SSC_PULSE_ZERO; // [RULE5]
			next_core.power = SSC_ACTIVE; // [RULE5] [RULE11]
		end else if (cnv_rise_core) begin
			if (core.pulses != `SSC_SLEEP_PULSES) begin
				next_core.pulses = `SSC_PULSE_W'(core.pulses + `SSC_PULSE_ONE);
			end
			if (core.pulses == `SSC_NAP_PULSES - `SSC_PULSE_ONE) begin
				next_core.power = SSC_NAP; // [RULE6]
			end else if (core.pulses >= `SSC_SLEEP_PULSES - `SSC_PULSE_ONE) begin
				next_core.power = SSC_SLEEP; // [RULE7]
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			core <= '0;
		end else begin
			core <= next_core;
		end
	end

	assign powered_down = core.power != SSC_ACTIVE;
	assign NAP_O = core.power == SSC_NAP;
	assign SLEEP_O = core.power == SSC_SLEEP;

	// link domain: everything here moves only on serial clock rises
	assign cnv_rise_link = link.cnv_s2 & ~link.cnv_s3;

	always_comb begin
		next_link = link;
		next_link.cnv_s1 = CONVERT_STROBE_I;
		next_link.cnv_s2 = link.cnv_s1;
		next_link.cnv_s3 = link.cnv_s2;
		next_link.sck_tog = ~link.sck_tog; // [RULE5]
		next_link.pd_s1 = powered_down;
		next_link.pd_s2 = link.pd_s1;
		// the input word only moves between conversions, so a plain two-stage
		// capture is enough; a word changing mid-capture would tear
		next_link.ain_s1 = AIN_DIFF_I;
		next_link.ain_s2 = link.ain_s1;
		if (link.busy) begin
			// convert edges during a frame fall through here unseen
			next_link.shift = {link.shift[`SSC_FRAME_W-2:0], 1'b0}; // [RULE2] [RULE8]
			next_link.cnt = `SSC_CNT_W'(link.cnt + `SSC_CNT_ONE); // [RULE2]
			if (link.cnt == `SSC_LAST_EDGE) begin
				next_link.busy = 1'b0; // [RULE8] [RULE9]
				next_link.acq = 1'b1; // [RULE10]
			end
		end else if (cnv_rise_link && !link.pd_s2) begin
			next_link.held = link.ain_s2; // [RULE1]
			next_link.shift = `SSC_FRAME_W'(link.held); // [RULE4]
			next_link.cnt = `SSC_CNT_ZERO;
			next_link.busy = 1'b1; // [RULE1] [RULE11]
			next_link.acq = 1'b0; // [RULE10]
		end
		if (link.pd_s2) begin
			// a frame in flight is abandoned on power-down
			next_link.busy = 1'b0; // [RULE12]
		end
	end

	always_ff @(posedge SCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	assign SDO_OE_O = link.busy; // [RULE3] [RULE12]
	assign SDO_O = link.shift[`SSC_FRAME_W-1] & link.busy; // [RULE3]
	assign ACQUIRE_O = link.acq;

endmodule

`default_nettype wire

// ---- ssc_convert_strobe_port_sva.sv ----
// output checker of the converter port
// bound onto ssc_convert_strobe_port
`timescale 1ns/100ps
`default_nettype none
module ssc_convert_strobe_port_sva (
	// clocks and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire logic SCK_I,
	// outputs
	input wire logic SDO_O,
	input wire logic SDO_OE_O,
	input wire logic ACQUIRE_O,
	input wire logic NAP_O,
	input wire logic SLEEP_O
);
	sequence start_s; $rose(SDO_OE_O); endsequence
	sequence body_s; SDO_OE_O [*8] ##1 SDO_OE_O [*7] ##1 !SDO_OE_O; endsequence
	frame_len_a: assert property (@(posedge SCK_I) disable iff (!RST_N_I)
		start_s |=> body_s) else $error("bad length");
	lead_zero_a: assert property (@(posedge SCK_I) disable iff (!RST_N_I)
		start_s |-> !SDO_O ##1 !SDO_O) else $error("bad lead");
	idle_low_a: assert property (@(posedge SCK_I) disable iff (!RST_N_I)
		!SDO_OE_O |-> !SDO_O) else $error("idle data");
	acq_start_a: assert property (@(posedge SCK_I) disable iff (!RST_N_I)
		$fell(SDO_OE_O) |-> ACQUIRE_O) else $error("no acquire");
	acq_end_a: assert property (@(posedge SCK_I) disable iff (!RST_N_I)
		start_s |-> !ACQUIRE_O) else $error("late acquire");
	pd_quiet_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		NAP_O || SLEEP_O |-> !SDO_OE_O) else $error("driven asleep");
	one_mode_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!(NAP_O && SLEEP_O)) else $error("two modes");
	wake_up_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		SCK_I != $past(SCK_I) |-> ##[1:6] !NAP_O && !SLEEP_O) else $error("no wake");
endmodule
bind ssc_convert_strobe_port ssc_convert_strobe_port_sva ssc_convert_strobe_port_sva_inst(.CORE_CLK_I, .RST_N_I, .SCK_I,
	.SDO_O, .SDO_OE_O, .ACQUIRE_O, .NAP_O, .SLEEP_O);
`default_nettype wire

// ---- ssc_host_model.sv ----
// host model: serial clock, strobe, capture
// port drives sdo_i only under oe_i
`timescale 1ns/100ps
`default_nettype none
module ssc_host_model (
	// from port
	input wire logic sdo_i,
	input wire logic oe_i,
	// to port
	output logic sck_o = 1'b0,
	output logic cnv_o = 1'b0
);
	task automatic tick;
		#32 sck_o = 1'b1;
		#32 sck_o = 1'b0;
	endtask
	// sck static here, so strobes count as power-down
	task automatic pulse;
		cnv_o = 1'b1;
		#400 cnv_o = 1'b0;
		#400;
	endtask
	task automatic frame(output logic [15:0] w, output logic [15:0] n);
		w = 16'h0000;
		n = 16'h0000;
		repeat (3) tick();
		for (int i = 0; i < 20; i++) begin
			cnv_o = i < 6 || i > 9;
			tick();
			w = oe_i ? {w[14:0], sdo_i} : w;
			n = n + 16'(oe_i);
		end
		cnv_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- ssc_pkg.sv ----
// types shared by the serial converter control port
// assumes ssc_cfg.svh is on the include path
`include "ssc_cfg.svh"

package ssc_pkg;

	typedef enum logic [1:0] {
		SSC_ACTIVE,
		SSC_NAP,
		SSC_SLEEP
	} ssc_power_t;

	// core-domain state
	typedef struct packed {
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic cnv_s1;
		logic cnv_s2;
		logic cnv_s3;
		logic [`SSC_PULSE_W-1:0] pulses;
		ssc_power_t power;
	} ssc_core_t;

	// serial-clock-domain state
	typedef struct packed {
		logic cnv_s1;
		logic cnv_s2;
		logic cnv_s3;
		logic pd_s1;
		logic pd_s2;
		logic [`SSC_WORD_W-1:0] ain_s1;
		logic [`SSC_WORD_W-1:0] ain_s2;
		logic [`SSC_WORD_W-1:0] held;
		logic [`SSC_FRAME_W-1:0] shift;
		logic [`SSC_CNT_W-1:0] cnt;
		logic busy;
		logic acq;
		logic sck_tog;
	} ssc_link_t;

endpackage
